// ### logic/rerp_ctrl.sv
// Read error-recovery policy controller: mode flags, retry loop and error reporting.
// How it works
// - Early correction corrects on the first nonzero syndrome, skipping rereads if correctable.
// - Only data rereads are steered; seek and message retries are untouched.
// - Read-continuous masks early correction; early correction off means normal recovery.
// - Read-continuous sends every block at once and never raises check condition.
// - Transfer-bad-block set sends the unrecovered block in the same cycle as check condition.
// - Auto read reallocation requests reassignment on a stable nonzero syndrome.
// - Read-continuous masks auto read reallocation; shipped reset value sets it.
// - Auto write reallocation requests reassignment when a block cannot be written.
// - Retry count bounds the rereads before correction; reset value eight.
// - Correction handles one burst up to 48 or double burst up to 24 bits.
// - Default mode retries, corrects where possible, reports only uncorrectable errors.
// - Disable-correction alone retries, never corrects, halts and reports on failure.
// - Post-error alone recovers normally, reports recovered errors after the transfer.
// - Post-error with disable-correction reports reread recoveries after the transfer.
// - Post-error with stop-transfer retries, corrects, then halts on any error.
// - Post, stop and disable-correction retry without correction, failure is unrecoverable.
// - Early alone corrects at once if possible, otherwise retries, reports unrecoverable only.
// - Early with post-error reports all errors, recovered ones after the transfer.
// - Early, post and stop-transfer halt the transfer on any detected error.
// - Data-strobe offset and recovery-time bytes store nothing and read zero.
// - Stop-transfer acts only with post-error set and read-continuous clear.
// - Disable-correction suppresses correction unless read-continuous is set.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module rerp_ctrl #(
   parameter bit SHIPPED = 1'b1
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // Register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   // Read channel results
   input  wire logic        BLK_START,
   input  wire logic        REREAD_VALID,
   input  wire logic [15:0] SYND,
   input  wire logic [7:0]  ERR_SPAN,
   input  wire logic        ERR_DOUBLE,
   // Command framing and write faults
   input  wire logic        CMD_END,
   input  wire logic        WR_FAULT,
   // Recovery actions
   output logic             REREAD_REQ,
   output logic             ECC_APPLY,
   output logic             BLK_SEND,
   output logic             BLK_DONE,
   output logic             XFER_HALT,
   output logic             RD_REALLOC,
   output logic             WR_REALLOC,
   // Status towards the initiator
   output logic             CHECK_COND,
   output logic      [3:0]  SENSE_KEY,
   output logic             BUSY
);

   localparam logic [7:0] RST_FLAGS = SHIPPED ? rerp_pkg::RST_FLAGS_SHIPPED
                                              : rerp_pkg::RST_FLAGS_STORED;

   // Pattern order is early, post, stop-transfer, disable-correction.
   function automatic logic flags_legal(input logic [3:0] p);
      logic ok;
      ok = 1'b1;
      if (p == 4'h2 || p == 4'h3 || p == 4'h9 || p == 4'hA ||
          p == 4'hB || p == 4'hD || p == 4'hF) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : flags_legal

   // Stored settings.
   logic [7:0]  flags_ff;
   logic [7:0]  retry_ff;
   logic [7:0]  span_ff;
   logic        invalid_ff;
   logic [7:0]  rdata_ff;

   // Recovery engine.
   rerp_pkg::rerp_state_t state_ff;
   rerp_pkg::rerp_state_t nxt_state;
   logic [7:0]  tries_ff;
   logic [7:0]  nxt_tries;
   logic [15:0] prev_synd_ff;
   logic        pending_ff;
   logic        halted_ff;

   // Registered outputs.
   logic        reread_ff;
   logic        ecc_ff;
   logic        send_ff;
   logic        done_ff;
   logic        halt_ff;
   logic        rd_real_ff;
   logic        wr_real_ff;
   logic        check_ff;
   logic [3:0]  sense_ff;
   logic        busy_ff;

   // Effective flags after masking.
   wire         read_cont   = flags_ff[rerp_pkg::BIT_READ_CONT];
   wire         post_err    = flags_ff[rerp_pkg::BIT_POST_ERROR];
   wire         early_eff   = flags_ff[rerp_pkg::BIT_EARLY_CORR] & ~read_cont;
   wire         stop_eff    = flags_ff[rerp_pkg::BIT_STOP_XFER] & post_err
                              & ~read_cont;
   wire         nocorr_eff  = flags_ff[rerp_pkg::BIT_DISABLE_CORR] & ~read_cont;
   wire         xfer_bad    = flags_ff[rerp_pkg::BIT_XFER_BAD];
   wire         rd_real_eff = flags_ff[rerp_pkg::BIT_AUTO_RD_REAL] & ~read_cont;
   wire         wr_real_eff = flags_ff[rerp_pkg::BIT_AUTO_WR_REAL];

   // Register decoding.
   wire         wr_flags = WR && (ADDR == rerp_pkg::OFS_FLAGS);
   wire         wr_retry = WR && (ADDR == rerp_pkg::OFS_RETRY);
   wire         wr_span  = WR && (ADDR == rerp_pkg::OFS_SPAN);
   wire         wr_stat  = WR && (ADDR == rerp_pkg::OFS_STATUS);
   wire [3:0]   wr_pat   = {WDATA[rerp_pkg::BIT_EARLY_CORR], WDATA[rerp_pkg::BIT_POST_ERROR],
                            WDATA[rerp_pkg::BIT_STOP_XFER], WDATA[rerp_pkg::BIT_DISABLE_CORR]};
   wire         wr_bad   = wr_flags && !flags_legal(wr_pat);
   wire [7:0]   status   = {4'h0, halted_ff, pending_ff, (state_ff == rerp_pkg::ST_WAIT),
                            invalid_ff};
   logic [7:0]  rd_mux;

   // Bytes five to seven and unmapped offsets read zero.
   always_comb begin
      if (ADDR == rerp_pkg::OFS_FLAGS) begin
         rd_mux = flags_ff;
      end else if (ADDR == rerp_pkg::OFS_RETRY) begin
         rd_mux = retry_ff;
      end else if (ADDR == rerp_pkg::OFS_SPAN) begin
         rd_mux = span_ff;
      end else if (ADDR == rerp_pkg::OFS_STATUS) begin
         rd_mux = status;
      end else begin
         rd_mux = 8'h00;
      end
   end

   // Correctability of the current error within the programmed span.
   wire [7:0]   burst_max = ERR_DOUBLE ? rerp_pkg::MAX_DOUBLE_BURST
                                       : rerp_pkg::MAX_SINGLE_BURST;
   wire         in_span   = (ERR_SPAN <= burst_max) && (ERR_SPAN <= span_ff);
   wire         corr_ok   = in_span && !nocorr_eff;

   // Classification of the result on the read channel.
   wire         first     = BLK_START && (state_ff == rerp_pkg::ST_IDLE);
   wire         reread    = REREAD_VALID && (state_ff == rerp_pkg::ST_WAIT);
   wire         synd_zero = (SYND == 16'h0000);
   wire         stable    = reread && !synd_zero && (SYND == prev_synd_ff);
   // The count is taken from the flop side so the retry decision does not loop on itself.
   wire [7:0]   tries_inc = tries_ff + 8'h01;
   wire         exhausted = (tries_inc >= retry_ff);

   // Outcome of this cycle.
   logic        res_good;
   logic        res_ignore;
   logic        res_corr;
   logic        res_unrec;
   logic        res_reread;
   logic        res_retried;

   always_comb begin
      nxt_state   = state_ff;
      nxt_tries   = tries_ff;
      res_good    = 1'b0;
      res_ignore  = 1'b0;
      res_corr    = 1'b0;
      res_unrec   = 1'b0;
      res_reread  = 1'b0;
      res_retried = 1'b0;
      if (first) begin
         nxt_tries = 8'h00;
         if (synd_zero) begin
            res_good = 1'b1;
         end else if (read_cont) begin
            res_ignore = 1'b1;
         end else if (early_eff && corr_ok) begin
            res_corr = 1'b1;
         end else if (retry_ff == 8'h00) begin
            res_corr  = corr_ok;
            res_unrec = !corr_ok;
         end else begin
            res_reread = 1'b1;
            nxt_state  = rerp_pkg::ST_WAIT;
         end
      end else if (reread) begin
         nxt_tries   = tries_inc;
         res_retried = 1'b1;
         if (synd_zero) begin
            res_good = 1'b1;
         end else if (stable || exhausted) begin
            res_corr  = corr_ok;
            res_unrec = !corr_ok;
         end else begin
            res_reread = 1'b1;
         end
         if (!res_reread) begin
            nxt_state = rerp_pkg::ST_IDLE;
         end
      end
   end

   // Block-level decisions.
   wire         resolved  = res_good || res_ignore || res_corr || res_unrec;
   wire         recovered = res_corr || (res_good && res_retried);
   wire         send      = res_good || res_ignore || res_corr
                            || (res_unrec && xfer_bad);
   wire         halt_now  = res_unrec || (recovered && stop_eff);
   wire         defer     = recovered && post_err && !stop_eff;
   // A recovery that resolves in the command's last cycle is reported, not lost to the clear.
   wire         end_check = CMD_END && (pending_ff || defer) && !halted_ff;

   // Sense key for the check condition raised in this cycle.
   wire [3:0]   nxt_sense = res_unrec ? rerp_pkg::SENSE_MEDIUM
                                      : rerp_pkg::SENSE_RECOVERED;

   // Register file.
   always_ff @(posedge CLK) begin
      if (RST) begin
         flags_ff <= RST_FLAGS;
      end else if (wr_flags && !wr_bad) begin
         flags_ff <= WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         retry_ff <= rerp_pkg::RST_RETRY;
      end else if (wr_retry) begin
         retry_ff <= WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         span_ff <= rerp_pkg::RST_SPAN;
      end else if (wr_span) begin
         span_ff <= WDATA;
      end
   end

   // A new refusal wins over a clear in the same cycle.
   always_ff @(posedge CLK) begin
      if (RST) begin
         invalid_ff <= 1'b0;
      end else if (wr_bad) begin
         invalid_ff <= 1'b1;
      end else if (wr_stat && WDATA[rerp_pkg::BIT_ST_INVALID]) begin
         invalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= RD ? rd_mux : 8'h00;
      end
   end

   // Engine state and retry tracking.
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_ff     <= rerp_pkg::ST_IDLE;
         tries_ff     <= 8'h00;
         prev_synd_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         tries_ff <= nxt_tries;
         if (first || reread) begin
            prev_synd_ff <= SYND;
         end
      end
   end

   // Deferred report for the current command.
   always_ff @(posedge CLK) begin
      if (RST) begin
         pending_ff <= 1'b0;
      end else if (CMD_END) begin
         pending_ff <= 1'b0;
      end else if (defer) begin
         pending_ff <= 1'b1;
      end
   end

   // Halt bookkeeping for the current command.
   always_ff @(posedge CLK) begin
      if (RST) begin
         halted_ff <= 1'b0;
      end else if (CMD_END) begin
         halted_ff <= 1'b0;
      end else if (halt_now) begin
         halted_ff <= 1'b1;
      end
   end

   // Action pulses; rereads are data rereads only, positioning is left alone.
   always_ff @(posedge CLK) begin
      if (RST) begin
         reread_ff  <= 1'b0;
         ecc_ff     <= 1'b0;
         send_ff    <= 1'b0;
         done_ff    <= 1'b0;
         halt_ff    <= 1'b0;
      end else begin
         reread_ff  <= res_reread;
         ecc_ff     <= res_corr;
         send_ff    <= send;
         done_ff    <= resolved;
         halt_ff    <= halt_now;
      end
   end

   // Reallocation requests.
   always_ff @(posedge CLK) begin
      if (RST) begin
         rd_real_ff <= 1'b0;
         wr_real_ff <= 1'b0;
      end else begin
         rd_real_ff <= stable && rd_real_eff;
         wr_real_ff <= WR_FAULT && wr_real_eff;
      end
   end

   // Check condition for halts and deferred reports.
   always_ff @(posedge CLK) begin
      if (RST) begin
         check_ff <= 1'b0;
      end else begin
         check_ff <= halt_now || end_check;
      end
   end

   // Sense key; an unrecovered error overrides a deferred recovered one.
   // The key is cleared at each block start so a stale key is never shown.
   always_ff @(posedge CLK) begin
      if (RST) begin
         sense_ff <= rerp_pkg::SENSE_NONE;
      end else if (halt_now) begin
         sense_ff <= nxt_sense;
      end else if (end_check) begin
         sense_ff <= rerp_pkg::SENSE_RECOVERED;
      end else if (first) begin
         sense_ff <= rerp_pkg::SENSE_NONE;
      end
   end

   // Busy follows the engine state from a flop of its own.
   always_ff @(posedge CLK) begin
      if (RST) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state == rerp_pkg::ST_WAIT);
      end
   end

   assign RDATA      = rdata_ff;
   assign REREAD_REQ = reread_ff;
   assign ECC_APPLY  = ecc_ff;
   assign BLK_SEND   = send_ff;
   assign BLK_DONE   = done_ff;
   assign XFER_HALT  = halt_ff;
   assign RD_REALLOC = rd_real_ff;
   assign WR_REALLOC = wr_real_ff;
   assign CHECK_COND = check_ff;
   assign SENSE_KEY  = sense_ff;
   assign BUSY       = busy_ff;

endmodule : rerp_ctrl

// ### logic/rerp_pkg.sv
// Shared constants for the read error-recovery policy controller.
package rerp_pkg;

   // Register offsets, one byte each.
   localparam logic [3:0] OFS_FLAGS  = 4'h2;
   localparam logic [3:0] OFS_RETRY  = 4'h3;
   localparam logic [3:0] OFS_SPAN   = 4'h4;
   localparam logic [3:0] OFS_RSV5   = 4'h5;
   localparam logic [3:0] OFS_RSV6   = 4'h6;
   localparam logic [3:0] OFS_RSV7   = 4'h7;
   localparam logic [3:0] OFS_STATUS = 4'h8;

   // Bit positions in the flags byte.
   localparam int BIT_DISABLE_CORR = 0;
   localparam int BIT_STOP_XFER    = 1;
   localparam int BIT_POST_ERROR   = 2;
   localparam int BIT_EARLY_CORR   = 3;
   localparam int BIT_READ_CONT    = 4;
   localparam int BIT_XFER_BAD     = 5;
   localparam int BIT_AUTO_RD_REAL = 6;
   localparam int BIT_AUTO_WR_REAL = 7;

   // Bit positions in the status byte.
   localparam int BIT_ST_INVALID = 0;
   localparam int BIT_ST_BUSY    = 1;
   localparam int BIT_ST_PENDING = 2;
   localparam int BIT_ST_HALTED  = 3;

   // Values after reset.
   localparam logic [7:0] RST_FLAGS_STORED  = 8'h00;
   localparam logic [7:0] RST_FLAGS_SHIPPED = 8'hC0;
   localparam logic [7:0] RST_RETRY         = 8'h08;
   localparam logic [7:0] RST_SPAN          = 8'h10;

   // Correction limits in bits.
   localparam logic [7:0] MAX_SINGLE_BURST = 8'h30;
   localparam logic [7:0] MAX_DOUBLE_BURST = 8'h18;

   // Sense keys shown with a check condition.
   localparam logic [3:0] SENSE_NONE      = 4'h0;
   localparam logic [3:0] SENSE_RECOVERED = 4'h1;
   localparam logic [3:0] SENSE_MEDIUM    = 4'h3;

   // Recovery engine states.
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } rerp_state_t;

endpackage : rerp_pkg

// ### tb/rerp_sva.sv
// Checker bound to the ports of the error-recovery policy controller.
`timescale 1ns/100ps
module rerp_sva (
   // Clock, reset and register port
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic [3:0]  ADDR,
   input wire logic        RD,
   input wire logic [7:0]  RDATA,
   // Read channel and faults
   input wire logic        REREAD_VALID,
   input wire logic [15:0] SYND,
   input wire logic        WR_FAULT,
   // Actions and status
   input wire logic        REREAD_REQ,
   input wire logic        ECC_APPLY,
   input wire logic        BLK_SEND,
   input wire logic        BLK_DONE,
   input wire logic        XFER_HALT,
   input wire logic        RD_REALLOC,
   input wire logic        WR_REALLOC,
   input wire logic        CHECK_COND,
   input wire logic [3:0]  SENSE_KEY,
   input wire logic        BUSY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_wral; WR_REALLOC |-> $past(WR_FAULT); endproperty
   a_wral: assert property (p_wral) else $error("write realloc without fault");
   property p_rral; RD_REALLOC |-> $past(REREAD_VALID) && $past(BUSY); endproperty
   a_rral: assert property (p_rral) else $error("read realloc without reread");
   property p_ecc; ECC_APPLY |-> BLK_SEND && BLK_DONE; endproperty
   a_ecc: assert property (p_ecc) else $error("corrected block not sent");
   property p_halt; XFER_HALT |-> CHECK_COND; endproperty
   a_halt: assert property (p_halt) else $error("halt without check condition");
   property p_key; CHECK_COND |-> SENSE_KEY == 4'h1 || SENSE_KEY == 4'h3; endproperty
   a_key: assert property (p_key) else $error("bad sense key");
   property p_loop; $rose(BUSY) |-> REREAD_REQ; endproperty
   a_loop: assert property (p_loop) else $error("busy without reread");
   property p_good;
      REREAD_VALID && BUSY && SYND == 16'h0 |=> BLK_SEND && !BUSY && !ECC_APPLY;
   endproperty
   a_good: assert property (p_good) else $error("good reread not sent");
   property p_rsv; RD && ADDR >= 4'h5 && ADDR <= 4'h7 |=> RDATA == 8'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved byte not zero");
   c_med: cover property (CHECK_COND && SENSE_KEY == 4'h3);
   c_rral: cover property (RD_REALLOC);
   c_loop: cover property (BUSY && REREAD_REQ);
endmodule : rerp_sva
bind rerp_ctrl rerp_sva u_sva (.CLK, .RST, .ADDR, .RD, .RDATA, .REREAD_VALID, .SYND,
   .WR_FAULT, .REREAD_REQ, .ECC_APPLY, .BLK_SEND, .BLK_DONE, .XFER_HALT, .RD_REALLOC,
   .WR_REALLOC, .CHECK_COND, .SENSE_KEY, .BUSY);

// ### tb/rerp_chan.sv
// Read channel model: first reads of a block and answers to reread requests.
`timescale 1ns/100ps
module rerp_chan (
   // Clock and request
   input wire logic    clk,
   input wire logic    reread_req,
   // Results towards the controller
   output logic        blk_start = 1'b0,
   output logic        reread_valid = 1'b0,
   output logic [15:0] synd = 16'hFFFF,
   output logic [7:0]  err_span = 8'h0,
   output logic        err_double = 1'b0
);
   logic [15:0] rr [0:15];
   int          idx = 0;
   int          dly = 2;
   // Outside a result pulse the syndrome shows the inverse of its last value.
   task automatic blk(input logic [15:0] s, input logic [7:0] sp, input logic d);
      @(posedge clk);
      blk_start <= 1'b1;
      synd <= s;
      err_span <= sp;
      err_double <= d;
      idx = 0;
      @(posedge clk);
      blk_start <= 1'b0;
      synd <= ~s;
   endtask : blk
   always begin
      @(posedge clk);
      if (reread_req === 1'b1) begin
         repeat (dly) @(posedge clk);
         reread_valid <= 1'b1;
         synd <= rr[idx];
         @(posedge clk);
         reread_valid <= 1'b0;
         synd <= ~rr[idx];
         idx = idx + 1;
      end
   end
endmodule : rerp_chan

// ### tb/tb.sv
// Self-checking testbench for the error-recovery policy controller.
`timescale 1ns/100ps
module tb;
   localparam logic [15:0] ILLEGAL = 16'hAE0C;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0;
   logic        cmd_end = 1'b0, wr_fault = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h0;
   logic [7:0]  rdata, err_span;
   logic [15:0] synd;
   logic        blk_start, reread_valid, err_double, reread_req, ecc_apply, blk_send;
   logic        blk_done, xfer_halt, rd_realloc, wr_realloc, check_cond, busy;
   logic [3:0]  sense_key, key_cap;
   logic [3:0]  cn [0:6];
   int          done_n, fail_count = 0, check_count = 0;
   wire  [6:0]  ev = {reread_req, ecc_apply, blk_send, check_cond, xfer_halt, rd_realloc,
                      wr_realloc};
   initial forever #25 clk = ~clk;
   rerp_ctrl dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .BLK_START(blk_start), .REREAD_VALID(reread_valid), .SYND(synd),
      .ERR_SPAN(err_span), .ERR_DOUBLE(err_double), .CMD_END(cmd_end), .WR_FAULT(wr_fault),
      .REREAD_REQ(reread_req), .ECC_APPLY(ecc_apply), .BLK_SEND(blk_send),
      .BLK_DONE(blk_done), .XFER_HALT(xfer_halt), .RD_REALLOC(rd_realloc),
      .WR_REALLOC(wr_realloc), .CHECK_COND(check_cond), .SENSE_KEY(sense_key), .BUSY(busy));
   rerp_chan ch (.clk(clk), .reread_req(reread_req), .blk_start(blk_start),
      .reread_valid(reread_valid), .synd(synd), .err_span(err_span), .err_double(err_double));
   always @(posedge clk) begin
      for (int k = 0; k < 7; k++) cn[k] <= clr ? 4'h0 : cn[k] + 4'(ev[k] === 1'b1);
      done_n <= clr ? 0 : done_n + int'(blk_done === 1'b1);
      if (clr) key_cap <= 4'h0;
      else if (check_cond === 1'b1) key_cap <= sense_key;
   end
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk8
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk32
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk8(rdata, e);
   endtask : rchk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // Expected value nibbles: rereads, ecc, send, check, halt, read realloc, write realloc, key.
   task automatic run(input logic [7:0] f, r, sp, input logic [15:0] r0, r1,
                      input logic [7:0] es, input logic d, input logic [31:0] e);
      int n;
      wreg(rerp_pkg::OFS_FLAGS, f);
      wreg(rerp_pkg::OFS_RETRY, r);
      wreg(rerp_pkg::OFS_SPAN, sp);
      for (n = 0; n < 16; n++) ch.rr[n] = (n == 0) ? r0 : r1;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      ch.blk(16'h5, es, d);
      for (n = 0; n < 200 && done_n == 0; n++) @(posedge clk);
      chk32({31'h0, done_n != 0}, 32'h1);
      if (done_n == 0) wrap_up();
      @(posedge clk);
      cmd_end <= 1'b1;
      wr_fault <= 1'b1;
      @(posedge clk);
      cmd_end <= 1'b0;
      wr_fault <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk32({cn[6], cn[5], cn[4], cn[3], cn[2], cn[1], cn[0], key_cap}, e);
      $display("block case done, flags %h", f);
   endtask : run
   initial begin
      logic [7:0] prev;
      logic       ill;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(rerp_pkg::OFS_FLAGS, 8'hC0);
      rchk(rerp_pkg::OFS_RETRY, 8'h08);
      rchk(rerp_pkg::OFS_SPAN, 8'h10);
      for (int a = 5; a < 8; a++) begin
         wreg(4'(a), 8'hA5);
         rchk(4'(a), 8'h0);
      end
      rchk(4'h9, 8'h0);
      prev = 8'hC0;
      for (int i = 0; i < 16; i++) begin
         ill = ILLEGAL[i];
         wreg(rerp_pkg::OFS_FLAGS, 8'(i));
         if (!ill) prev = 8'(i);
         rchk(rerp_pkg::OFS_FLAGS, prev);
         rchk(rerp_pkg::OFS_STATUS, {7'h0, ill});
         wreg(rerp_pkg::OFS_STATUS, 8'h01);
      end
      $display("register tests done");
      run(8'h00, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h1110_0000);
      run(8'hC0, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h1110_0110);
      run(8'hD8, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h0010_0010);
      run(8'h08, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h0110_0000);
      run(8'h08, 8'h08, 8'h10, 16'h7, 16'h7, 8'h28, 1'b0, 32'h2001_1003);
      run(8'h28, 8'h08, 8'h10, 16'h7, 16'h7, 8'h28, 1'b0, 32'h2011_1003);
      run(8'h01, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h1001_1003);
      run(8'h06, 8'h08, 8'h10, 16'h0, 16'h0, 8'h08, 1'b0, 32'h1011_1001);
      run(8'h04, 8'h08, 8'h10, 16'h0, 16'h0, 8'h08, 1'b0, 32'h1011_0001);
      ch.dly = 0;
      run(8'h00, 8'h02, 8'h10, 16'h1, 16'h2, 8'h08, 1'b0, 32'h2110_0000);
      run(8'h00, 8'h00, 8'h30, 16'h5, 16'h5, 8'h30, 1'b0, 32'h0110_0000);
      run(8'h00, 8'h00, 8'h30, 16'h5, 16'h5, 8'h19, 1'b1, 32'h0001_1003);
      run(8'h0C, 8'h08, 8'h10, 16'h0, 16'h0, 8'h28, 1'b0, 32'h1011_0001);
      run(8'h0E, 8'h08, 8'h10, 16'h0, 16'h0, 8'h08, 1'b0, 32'h0111_1001);
      run(8'h05, 8'h08, 8'h10, 16'h0, 16'h0, 8'h08, 1'b0, 32'h1011_0001);
      run(8'h07, 8'h08, 8'h10, 16'h5, 16'h5, 8'h08, 1'b0, 32'h1001_1003);
      wrap_up();
   end
endmodule : tb
